// >>> inc/irq_map_pkg.sv
package irq_map_pkg;

  // ==========================================================
  // source numbering
  localparam int          N_SRC     = 50;
  localparam int          LVL_W     = 4;
  localparam logic [5:0]  IDX_CC6   = 6'h00;
  localparam logic [5:0]  IDX_CC16  = 6'h0a;
  localparam logic [5:0]  IDX_CC29  = 6'h17;
  localparam logic [5:0]  IDX_T0    = 6'h1a;
  localparam logic [5:0]  IDX_T7    = 6'h1c;
  localparam logic [5:0]  IDX_GPT   = 6'h1e;
  localparam logic [5:0]  IDX_ADC   = 6'h24;
  localparam logic [5:0]  IDX_ASC   = 6'h26;
  localparam logic [5:0]  IDX_ASCTB = 6'h29;
  localparam logic [5:0]  IDX_SYNC  = 6'h2a;
  localparam logic [5:0]  IDX_PWM   = 6'h2d;
  localparam logic [5:0]  IDX_XP    = 6'h2e;

  // ==========================================================
  // trap numbers of the first source of each group
  localparam logic [6:0]  TRAP_CC6   = 7'h16;
  localparam logic [6:0]  TRAP_CC16  = 7'h30;
  localparam logic [6:0]  TRAP_CC29  = 7'h44;
  localparam logic [6:0]  TRAP_T0    = 7'h20;
  localparam logic [6:0]  TRAP_T7    = 7'h3d;
  localparam logic [6:0]  TRAP_GPT   = 7'h22;
  localparam logic [6:0]  TRAP_ADC   = 7'h28;
  localparam logic [6:0]  TRAP_ASC   = 7'h2a;
  localparam logic [6:0]  TRAP_ASCTB = 7'h47;
  localparam logic [6:0]  TRAP_SYNC  = 7'h2d;
  localparam logic [6:0]  TRAP_PWM   = 7'h3f;
  localparam logic [6:0]  TRAP_XP    = 7'h40;

  // ==========================================================
  // hardware traps
  localparam logic [6:0]  TRAP_NMI       = 7'h02;
  localparam logic [6:0]  TRAP_STK_OVER  = 7'h04;
  localparam logic [6:0]  TRAP_STK_UNDER = 7'h06;
  localparam logic [6:0]  TRAP_CLASS_B   = 7'h0a;
  localparam int          N_HWTRAP       = 9;
  localparam logic [3:0]  FLG_NMI        = 4'hf;
  localparam logic [3:0]  FLG_STK_OVER   = 4'he;
  localparam logic [3:0]  FLG_STK_UNDER  = 4'hd;
  localparam logic [3:0]  FLG_BAD_OPCODE = 4'h7;
  localparam logic [3:0]  FLG_MAC        = 4'h6;
  localparam logic [3:0]  FLG_PROTECT    = 4'h3;
  localparam logic [3:0]  FLG_BAD_OPND   = 4'h2;
  localparam logic [3:0]  FLG_BAD_FETCH  = 4'h1;
  localparam logic [3:0]  FLG_BAD_BUS    = 4'h0;
  localparam logic [15:0] FLG_RESET      = 16'h0000;
  localparam logic [3:0]  LVL_TRAP       = 4'hf;

  // ==========================================================
  // source index to trap number; vector is trap number times four
  function automatic logic [6:0] trap_of(input logic [5:0] i);
    if (i < IDX_CC16)
      return TRAP_CC6 + 7'(i - IDX_CC6);
    else if (i < IDX_CC29)
      return TRAP_CC16 + 7'(i - IDX_CC16);
    else if (i < IDX_T0)
      return TRAP_CC29 + 7'(i - IDX_CC29);
    else if (i < IDX_T7)
      return TRAP_T0 + 7'(i - IDX_T0);
    else if (i < IDX_GPT)
      return TRAP_T7 + 7'(i - IDX_T7);
    else if (i < IDX_ADC)
      return TRAP_GPT + 7'(i - IDX_GPT);
    else if (i < IDX_ASC)
      return TRAP_ADC + 7'(i - IDX_ADC);
    else if (i < IDX_ASCTB)
      return TRAP_ASC + 7'(i - IDX_ASC);
    else if (i < IDX_SYNC)
      return TRAP_ASCTB;
    else if (i < IDX_PWM)
      return TRAP_SYNC + 7'(i - IDX_SYNC);
    else if (i < IDX_XP)
      return TRAP_PWM;
    else
      return TRAP_XP + 7'(i - IDX_XP);
  endfunction

  function automatic logic [8:0] vec_of(input logic [6:0] t);
    return {t, 2'b00};
  endfunction

endpackage

// >>> rtl/irq_arbiter.sv
module irq_arbiter #(
  parameter int N  = 50,
  parameter int LW = 4,
  parameter int IW = 6
) (
  input  wire logic [N-1:0]    pend,
  input  wire logic [N*LW-1:0] level,
  input  wire logic [LW-1:0]   floor_lvl,
  output logic                 found,
  output logic [IW-1:0]        idx,
  output logic [LW-1:0]        lvl
);

  // ==========================================================
  // strictly-greater compare: equal levels keep the lower index,
  // and nothing at or below the running cpu level can win
  always_comb
  begin
    found = 1'b0;
    idx   = '0;
    lvl   = floor_lvl;
    for (int i = 0; i < N; i++)
    begin
      if (pend[i] && (level[i*LW +: LW] > lvl))
      begin
        found = 1'b1;
        lvl   = level[i*LW +: LW];
        idx   = IW'(i);
      end
    end
  end

endmodule

// >>> rtl/trap_unit.sv
module trap_unit (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [8:0]  hw_trap,
  input  wire logic [15:0] tflg_clr,
  input  wire logic        take,
  input  wire logic [6:0]  take_num,
  input  wire logic        trap_return,
  output logic             offer,
  output logic [6:0]       offer_num,
  output logic             svc_any,
  output logic [15:0]      tflg
);

  // ==========================================================
  // pending traps and service state
  logic [2:0]  pend_a_r;
  logic        pend_b_r;
  logic        svc_a_r;
  logic        svc_b_r;
  logic        svc_any_r;
  logic [15:0] tflg_r;
  logic [15:0] tflg_set;
  logic [2:0]  clr_a;
  logic        take_b;
  logic        ret_a;
  logic        ret_b;
  logic        offer_a;
  logic        offer_b;
  logic        svc_a_nxt;
  logic        svc_b_nxt;

  assign clr_a[0]  = take && (take_num == irq_map_pkg::TRAP_NMI);
  assign clr_a[1]  = take && (take_num == irq_map_pkg::TRAP_STK_OVER);
  assign clr_a[2]  = take && (take_num == irq_map_pkg::TRAP_STK_UNDER);
  assign take_b    = take && (take_num == irq_map_pkg::TRAP_CLASS_B);
  assign ret_a     = trap_return && svc_a_r;
  assign ret_b     = trap_return && !svc_a_r;
  // class a may cut into class b service, never the reverse
  assign offer_a   = (|pend_a_r) && !svc_a_r;  // R14
  assign offer_b   = pend_b_r && !svc_a_r && !svc_b_r;  // R14
  assign offer     = offer_a || offer_b;  // R12
  assign offer_num = pend_a_r[0] ? irq_map_pkg::TRAP_NMI :
                     pend_a_r[1] ? irq_map_pkg::TRAP_STK_OVER :
                     offer_a     ? irq_map_pkg::TRAP_STK_UNDER : irq_map_pkg::TRAP_CLASS_B;
  assign svc_a_nxt = (svc_a_r && !ret_a) || (|clr_a);
  assign svc_b_nxt = (svc_b_r && !ret_b) || take_b;
  assign svc_any   = svc_any_r;
  assign tflg      = tflg_r;

  always_comb
  begin
    tflg_set                              = '0;
    tflg_set[irq_map_pkg::FLG_NMI]        = hw_trap[0];
    tflg_set[irq_map_pkg::FLG_STK_OVER]   = hw_trap[1];
    tflg_set[irq_map_pkg::FLG_STK_UNDER]  = hw_trap[2];
    tflg_set[irq_map_pkg::FLG_BAD_OPCODE] = hw_trap[3];
    tflg_set[irq_map_pkg::FLG_MAC]        = hw_trap[4];
    tflg_set[irq_map_pkg::FLG_PROTECT]    = hw_trap[5];
    tflg_set[irq_map_pkg::FLG_BAD_OPND]   = hw_trap[6];
    tflg_set[irq_map_pkg::FLG_BAD_FETCH]  = hw_trap[7];
    tflg_set[irq_map_pkg::FLG_BAD_BUS]    = hw_trap[8];
  end

  // ==========================================================
  // new occurrences win over same-cycle clears
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pend_a_r  <= '0;
      pend_b_r  <= 1'b0;
      svc_a_r   <= 1'b0;
      svc_b_r   <= 1'b0;
      svc_any_r <= 1'b0;
      tflg_r    <= irq_map_pkg::FLG_RESET;
    end
    else
    begin
      pend_a_r  <= (pend_a_r & ~clr_a) | hw_trap[2:0];  // R12
      pend_b_r  <= (pend_b_r && !take_b) || (|hw_trap[8:3]);
      svc_a_r   <= svc_a_nxt;
      svc_b_r   <= svc_b_nxt;
      svc_any_r <= svc_a_nxt || svc_b_nxt;
      tflg_r    <= (tflg_r & ~tflg_clr) | tflg_set;  // R13
    end
  end

  // ==========================================================
  a_tflg_set: assert property (@(posedge clk) disable iff (!reset_n)  // R13
    hw_trap[0] |=> tflg_r[irq_map_pkg::FLG_NMI])
    else $error("trap flag not set by nmi");

  a_class_a_preempt: assert property (@(posedge clk) disable iff (!reset_n)  // R14
    (svc_b_r && !svc_a_r && (|pend_a_r)) |-> (offer && offer_num != irq_map_pkg::TRAP_CLASS_B))
    else $error("class a trap not offered over class b service");

endmodule

// >>> rtl/interrupt_vector_and_hw_trap_map.sv
// Functional notes
// R01: capture/compare channels 6-15 vector from 0x58, traps 0x16..0x1f, step four.
// R02: capture/compare channels 16-28 vector from 0xc0, traps from 0x30 to 0x3c.
// R03: capture/compare channels 29-31 vector from 0x110, traps 0x44..0x46.
// R04: capture/compare timers 0 and 1 vector from 0x80, traps from 0x20.
// R05: capture/compare timers 7 and 8 vector from 0xf4, traps from 0x3d.
// R06: general timers 2-6 and capture-reload vector consecutively, traps 0x22..0x27.
// R07: conversion done uses 0xa0/0x28; conversion overrun the next, 0xa4/0x29.
// R08: async serial tx, rx, error use traps from 0x2a; tx buffer 0x11c/0x47.
// R09: sync serial tx, rx, error vector from 0xb4, traps 0x2d..0x2f.
// R10: pwm request uses vector 0xfc, trap 0x3f.
// R11: four shared peripheral lines vector from 0x100, traps 0x40..0x43.
// R12: a hardware trap branches at once and unmaskably to its own vector; here the six class b traps share trap 0x0a.
// R13: each hardware trap sets its own bit in the trap flag register.
// R14: a trap preempts anything except a higher priority trap service; here no trap preempts a service of its own class.
// R15: trap service blocks standard interrupts and event transfer requests.
// R16: each source has request flag, enable flag and sixteen-level priority.
// R17: a running service is interrupted only by strictly higher priority.
// R18: vector location is the trap number shifted left by two.
module interrupt_vector_and_hw_trap_map (
  input  wire logic                                          clk,
  input  wire logic                                          reset_n,
  input  wire logic [irq_map_pkg::N_SRC-1:0]                 src_req,
  input  wire logic [irq_map_pkg::N_SRC-1:0]                 req_clr,
  input  wire logic [irq_map_pkg::N_SRC-1:0]                 src_enable,
  input  wire logic [irq_map_pkg::N_SRC*irq_map_pkg::LVL_W-1:0] src_level,
  input  wire logic [3:0]                                    cpu_level,
  input  wire logic                                          cpu_ack,
  input  wire logic                                          trap_return,
  input  wire logic [irq_map_pkg::N_HWTRAP-1:0]              hw_trap,
  input  wire logic [15:0]                                   tflg_clr,
  output logic [irq_map_pkg::N_SRC-1:0]                      req_flag,
  output logic                                               vec_valid,
  output logic                                               vec_is_trap,
  output logic [5:0]                                         vec_src,
  output logic [6:0]                                         vec_trap,
  output logic [8:0]                                         vec_addr,
  output logic [3:0]                                         vec_level,
  output logic                                               trap_busy,
  output logic                                               evt_block,
  output logic [15:0]                                        trap_flag_register
);

  // ==========================================================
  // request flags and arbitration
  logic [irq_map_pkg::N_SRC-1:0] req_flag_r;
  logic [irq_map_pkg::N_SRC-1:0] ack_clr;
  logic [irq_map_pkg::N_SRC-1:0] pend;
  logic                          arb_found;
  logic [5:0]                    arb_idx;
  logic [3:0]                    arb_lvl;
  logic                          t_offer;
  logic [6:0]                    t_num;
  logic                          t_svc;
  logic [15:0]                   t_flags;
  logic                          acked;
  logic                          int_ok;
  logic                          vec_valid_r;
  logic                          vec_is_trap_r;
  logic [5:0]                    vec_src_r;
  logic [6:0]                    vec_trap_r;

  assign acked   = cpu_ack && vec_valid_r;
  assign ack_clr = (acked && !vec_is_trap_r) ? (irq_map_pkg::N_SRC'(1) << vec_src_r) : '0;
  assign pend    = req_flag_r & src_enable;  // R16
  // no standard request is offered while a trap is in service
  assign int_ok  = arb_found && !t_svc;  // R15

  irq_arbiter #(
    .N  (irq_map_pkg::N_SRC),
    .LW (irq_map_pkg::LVL_W),
    .IW (6)
  ) u_arb (
    .pend      (pend),
    .level     (src_level),
    .floor_lvl (cpu_level),
    .found     (arb_found),
    .idx       (arb_idx),
    .lvl       (arb_lvl)
  );

  trap_unit u_trap (
    .clk         (clk),
    .reset_n     (reset_n),
    .hw_trap     (hw_trap),
    .tflg_clr    (tflg_clr),
    .take        (acked && vec_is_trap_r),
    .take_num    (vec_trap_r),
    .trap_return (trap_return),
    .offer       (t_offer),
    .offer_num   (t_num),
    .svc_any     (t_svc),
    .tflg        (t_flags)
  );

  // ==========================================================
  // vector offer towards the cpu
  logic [8:0] vec_addr_r;
  logic [3:0] vec_level_r;
  logic       vec_valid_nxt;
  logic       vec_is_trap_nxt;
  logic [5:0] vec_src_nxt;
  logic [6:0] vec_trap_nxt;
  logic [3:0] vec_level_nxt;
  logic       busy_r;

  // the offer is rebuilt every cycle so a trap displaces a waiting
  // interrupt offer; an acked offer drops for one cycle so the
  // stale flag is never shown twice
  assign vec_valid_nxt   = !acked && (t_offer || int_ok);  // R12
  assign vec_is_trap_nxt = t_offer;  // R14
  assign vec_src_nxt     = t_offer ? 6'h00 : arb_idx;
  assign vec_trap_nxt    = t_offer ? t_num : irq_map_pkg::trap_of(arb_idx);  // R01 R02 R03 R04 R05 R06
  assign vec_level_nxt   = t_offer ? irq_map_pkg::LVL_TRAP : arb_lvl;  // R17

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      req_flag_r    <= '0;
      vec_valid_r   <= 1'b0;
      vec_is_trap_r <= 1'b0;
      vec_src_r     <= '0;
      vec_trap_r    <= '0;
      vec_addr_r    <= '0;
      vec_level_r   <= '0;
      busy_r        <= 1'b0;
    end
    else
    begin
      req_flag_r    <= (req_flag_r & ~(req_clr | ack_clr)) | src_req;  // R16
      vec_valid_r   <= vec_valid_nxt;
      vec_is_trap_r <= vec_is_trap_nxt;
      vec_src_r     <= vec_src_nxt;
      vec_trap_r    <= vec_trap_nxt;  // R07 R08 R09 R10 R11
      vec_addr_r    <= irq_map_pkg::vec_of(vec_trap_nxt);  // R18
      vec_level_r   <= vec_level_nxt;
      busy_r        <= t_svc;
    end
  end

  assign req_flag           = req_flag_r;
  assign vec_valid          = vec_valid_r;
  assign vec_is_trap        = vec_is_trap_r;
  assign vec_src            = vec_src_r;
  assign vec_trap           = vec_trap_r;
  assign vec_addr           = vec_addr_r;
  assign vec_level          = vec_level_r;
  assign trap_busy          = t_svc;
  assign evt_block          = t_svc;  // R15
  assign trap_flag_register = t_flags;

  // ==========================================================
  // checks on the source map
  logic int_shown;

  assign int_shown = vec_valid_r && !vec_is_trap_r;

  function automatic logic grp_ok(input logic [5:0] s, input logic [6:0] t,
                                  input logic [5:0] first, input logic [5:0] cnt,
                                  input logic [6:0] base);
    if (s < first || s >= first + cnt)
      return 1'b1;
    return t == base + 7'(s - first);
  endfunction

  a_map_cc6: assert property (@(posedge clk) disable iff (!reset_n)  // R01
    int_shown |-> grp_ok(vec_src_r, vec_trap_r, irq_map_pkg::IDX_CC6, 6'd10, 7'h16))
    else $error("capture 6-15 trap number wrong");

  a_map_cc16: assert property (@(posedge clk) disable iff (!reset_n)  // R02
    int_shown |-> grp_ok(vec_src_r, vec_trap_r, irq_map_pkg::IDX_CC16, 6'd13, 7'h30))
    else $error("capture 16-28 trap number wrong");

  a_map_cc29: assert property (@(posedge clk) disable iff (!reset_n)  // R03
    int_shown |-> grp_ok(vec_src_r, vec_trap_r, irq_map_pkg::IDX_CC29, 6'd3, 7'h44))
    else $error("capture 29-31 trap number wrong");

  a_map_t0t1: assert property (@(posedge clk) disable iff (!reset_n)  // R04
    int_shown |-> grp_ok(vec_src_r, vec_trap_r, irq_map_pkg::IDX_T0, 6'd2, 7'h20))
    else $error("capture timer 0/1 trap number wrong");

  a_map_t7t8: assert property (@(posedge clk) disable iff (!reset_n)  // R05
    int_shown |-> grp_ok(vec_src_r, vec_trap_r, irq_map_pkg::IDX_T7, 6'd2, 7'h3d))
    else $error("capture timer 7/8 trap number wrong");

  a_map_gpt: assert property (@(posedge clk) disable iff (!reset_n)  // R06
    int_shown |-> grp_ok(vec_src_r, vec_trap_r, irq_map_pkg::IDX_GPT, 6'd6, 7'h22))
    else $error("general timer trap number wrong");

  a_map_adc: assert property (@(posedge clk) disable iff (!reset_n)  // R07
    (int_shown && vec_src_r == irq_map_pkg::IDX_ADC + 6'd1) |-> vec_addr_r == 9'h0a4)
    else $error("conversion overrun vector wrong");

  a_map_asc: assert property (@(posedge clk) disable iff (!reset_n)  // R08
    (int_shown && vec_src_r == irq_map_pkg::IDX_ASCTB) |-> (vec_trap_r == 7'h47 && vec_addr_r == 9'h11c))
    else $error("async tx buffer vector wrong");

  a_map_sync: assert property (@(posedge clk) disable iff (!reset_n)  // R09
    int_shown |-> grp_ok(vec_src_r, vec_trap_r, irq_map_pkg::IDX_SYNC, 6'd3, 7'h2d))
    else $error("sync serial trap number wrong");

  a_map_pwm: assert property (@(posedge clk) disable iff (!reset_n)  // R10
    (int_shown && vec_src_r == irq_map_pkg::IDX_PWM) |-> vec_addr_r == 9'h0fc)
    else $error("pwm vector wrong");

  a_map_xp: assert property (@(posedge clk) disable iff (!reset_n)  // R11
    int_shown |-> grp_ok(vec_src_r, vec_trap_r, irq_map_pkg::IDX_XP, 6'd4, 7'h40))
    else $error("shared peripheral trap number wrong");

  // ==========================================================
  // checks on traps and priority
  a_trap_prompt: assert property (@(posedge clk) disable iff (!reset_n)  // R12
    (hw_trap[0] && !t_svc) |-> ##[1:4] (t_svc || (vec_valid_r && vec_is_trap_r && vec_trap_r == 7'h02)))
    else $error("nmi not offered in time");

  a_trap_blocks: assert property (@(posedge clk) disable iff (!reset_n)  // R15
    busy_r |-> !int_shown && (evt_block || $past(trap_return)))
    else $error("standard request offered during trap service");

  a_flag_set: assert property (@(posedge clk) disable iff (!reset_n)  // R16
    src_req[0] |=> req_flag_r[0])
    else $error("request flag lost");

  a_higher_only: assert property (@(posedge clk) disable iff (!reset_n)  // R17
    int_shown |-> (vec_level_r > $past(cpu_level)) && $past(src_enable[arb_idx]))
    else $error("offer not above cpu level or not enabled");

  a_vec_shift: assert property (@(posedge clk) disable iff (!reset_n)  // R18
    vec_valid_r |-> vec_addr_r == {vec_trap_r, 2'b00})
    else $error("vector not trap number times four");

endmodule

// >>> dv/cpu_model.sv
// ==========================================================
// cpu core side: takes the shown vector after a programmable lag
module cpu_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       stall,
  input  wire logic [3:0] lag,
  input  wire logic       vec_valid,
  input  wire logic [5:0] vec_src,
  input  wire logic [6:0] vec_trap,
  input  wire logic [8:0] vec_addr,
  output logic            cpu_ack,
  output logic [5:0]      took_src,
  output logic [6:0]      took_trap,
  output logic [8:0]      took_addr,
  output int              took_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_r;

  // record at the ack edge itself: the offer may change right after it
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      cpu_ack   <= 1'b0;
      wait_r    <= 4'h0;
      took_src  <= 6'h00;
      took_trap <= 7'h00;
      took_addr <= 9'h000;
      took_cnt  <= 0;
    end
    else if (cpu_ack)
    begin
      cpu_ack   <= 1'b0;
      wait_r    <= 4'h0;
      took_src  <= vec_src;
      took_trap <= vec_trap;
      took_addr <= vec_addr;
      took_cnt  <= took_cnt + 1;
    end
    else if (vec_valid && !stall)
    begin
      if (wait_r == lag)
        cpu_ack <= 1'b1;
      else
        wait_r <= wait_r + 4'h1;
    end
    else
      wait_r <= 4'h0;
endmodule

// >>> dv/tb_interrupt_vector_and_hw_trap_map.sv
module tb_interrupt_vector_and_hw_trap_map;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NS = irq_map_pkg::N_SRC;
  localparam int BITPOS [9] = '{15, 14, 13, 7, 6, 3, 2, 1, 0};
  logic            clk, reset_n, cpu_ack, trap_return, stall;
  logic            vec_valid, vec_is_trap, trap_busy, evt_block;
  logic [NS-1:0]   src_req, req_clr, src_enable, req_flag;
  logic [NS*4-1:0] src_level;
  logic [3:0]      cpu_level, vec_level, lag;
  logic [8:0]      hw_trap, vec_addr, took_addr;
  logic [15:0]     tflg_clr, tflg;
  logic [5:0]      vec_src, took_src;
  logic [6:0]      vec_trap, took_trap;
  int              took_cnt, n_errors, num_checks, cyc;

  interrupt_vector_and_hw_trap_map u_interrupt_vector_and_hw_trap_map (
    .clk(clk), .reset_n(reset_n), .src_req(src_req), .req_clr(req_clr), .src_enable(src_enable),
    .src_level(src_level), .cpu_level(cpu_level), .cpu_ack(cpu_ack), .trap_return(trap_return),
    .hw_trap(hw_trap), .tflg_clr(tflg_clr), .req_flag(req_flag), .vec_valid(vec_valid),
    .vec_is_trap(vec_is_trap), .vec_src(vec_src), .vec_trap(vec_trap), .vec_addr(vec_addr),
    .vec_level(vec_level), .trap_busy(trap_busy), .evt_block(evt_block), .trap_flag_register(tflg));

  cpu_model u_cpu_model (
    .clk(clk), .reset_n(reset_n), .stall(stall), .lag(lag), .vec_valid(vec_valid), .vec_src(vec_src),
    .vec_trap(vec_trap), .vec_addr(vec_addr), .cpu_ack(cpu_ack), .took_src(took_src),
    .took_trap(took_trap), .took_addr(took_addr), .took_cnt(took_cnt));

  // ==========================================================
  // helpers
  function automatic logic [6:0] exp_trap(int i);
    if (i < 10) return 7'(32'h16 + i);
    if (i < 23) return 7'(32'h30 + i - 10);
    if (i < 26) return 7'(32'h44 + i - 23);
    if (i < 28) return 7'(32'h20 + i - 26);
    if (i < 30) return 7'(32'h3d + i - 28);
    if (i < 36) return 7'(32'h22 + i - 30);
    if (i < 38) return 7'(32'h28 + i - 36);
    if (i < 41) return 7'(32'h2a + i - 38);
    if (i == 41) return 7'h47;
    if (i < 45) return 7'(32'h2d + i - 42);
    if (i == 45) return 7'h3f;
    return 7'(32'h40 + i - 46);
  endfunction

  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic pulse_req(int i);
    @(negedge clk);
    src_req[i] = 1'b1;
    @(negedge clk);
    src_req[i] = 1'b0;
  endtask

  task automatic pulse_trap(int j);
    @(negedge clk);
    hw_trap[j] = 1'b1;
    @(negedge clk);
    hw_trap[j] = 1'b0;
  endtask

  task automatic pulse_ret();
    @(negedge clk);
    trap_return = 1'b1;
    @(negedge clk);
    trap_return = 1'b0;
  endtask

  task automatic clear_tflg();
    @(negedge clk);
    tflg_clr = 16'hffff;
    @(negedge clk);
    tflg_clr = 16'h0000;
  endtask

  // bounded wait for the cpu model to take one more vector
  task automatic wait_take();
    int n0;
    n0 = took_cnt;
    for (int k = 0; k < 40 && took_cnt == n0; k++)
      @(negedge clk);
    if (took_cnt == n0)
      chk("take_timeout", 16'h0000, 16'h0001);
  endtask

  // ==========================================================
  // scenarios
  task automatic map_all();
    logic [6:0] t;
    for (int i = 0; i < NS; i++)
    begin
      t = exp_trap(i);
      lag = 4'(i % 4);
      pulse_req(i);
      wait_take();
      chk("src", 16'(took_src), 16'(i));
      chk("trap", 16'(took_trap), 16'(t));
      chk("addr", 16'(took_addr), {7'h00, t, 2'b00});
      chk("flag_clr", 16'(req_flag[i]), 16'h0000);
    end
    lag = 4'h0;
  endtask

  task automatic prio_check();
    stall = 1'b1;
    src_level[20 +: 4] = 4'h3;
    src_level[80 +: 4] = 4'h5;
    src_level[28 +: 4] = 4'h2;
    src_level[36 +: 4] = 4'h7;
    src_enable[9] = 1'b0;
    cpu_level = 4'h2;
    @(negedge clk);
    src_req = (NS'(1) << 5) | (NS'(1) << 20) | (NS'(1) << 7) | (NS'(1) << 9);
    @(negedge clk);
    src_req = '0;
    repeat (2) @(negedge clk);
    chk("best_src", 16'(vec_src), 16'h0014);
    chk("best_lvl", 16'(vec_level), 16'h0005);
    stall = 1'b0;
    wait_take();
    chk("take_hi", 16'(took_src), 16'h0014);
    wait_take();
    chk("take_lo", 16'(took_src), 16'h0005);
    repeat (4) @(negedge clk);
    chk("no_offer", 16'(vec_valid), 16'h0000);
    chk("kept_flags", 16'({req_flag[9], req_flag[7]}), 16'h0003);
    req_clr[7] = 1'b1;
    req_clr[9] = 1'b1;
    @(negedge clk);
    req_clr = '0;
    @(negedge clk);
    chk("sw_clear", 16'({req_flag[9], req_flag[7]}), 16'h0000);
    src_enable = '1;
    src_level = {NS{4'h1}};
    cpu_level = 4'h0;
  endtask

  task automatic trap_check();
    stall = 1'b1;
    pulse_req(0);
    @(negedge clk);
    chk("irq_shown", 16'({vec_valid, vec_is_trap}), 16'h0002);
    pulse_trap(0);
    @(negedge clk);
    chk("trap_shown", 16'({vec_valid, vec_is_trap}), 16'h0003);
    chk("trap_vec", {vec_trap, vec_addr}, {7'h02, 9'h008});
    chk("trap_lvl", 16'(vec_level), 16'h000f);
    stall = 1'b0;
    wait_take();
    chk("busy", 16'({trap_busy, evt_block}), 16'h0003);
    pulse_trap(3);
    repeat (3) @(negedge clk);
    chk("b_held", 16'(vec_valid), 16'h0000);
    chk("b_flag", 16'(tflg[7]), 16'h0001);
    pulse_ret();
    wait_take();
    chk("b_take", 16'(took_trap), 16'h000a);
    pulse_trap(1);
    wait_take();
    chk("a_over_b", 16'(took_trap), 16'h0004);
    pulse_ret();
    pulse_ret();
    wait_take();
    chk("irq_after", 16'(took_trap), 16'h0016);
    clear_tflg();
    chk("tflg_cleared", tflg, 16'h0000);
    for (int j = 0; j < 9; j++)
    begin
      pulse_trap(j);
      wait_take();
      chk("code", 16'(took_trap), j < 3 ? 16'(2 * j + 2) : 16'h000a);
      chk("tflg_bit", tflg, 16'h0001 << BITPOS[j]);
      pulse_ret();
      @(negedge clk);
      chk("busy_end", 16'(trap_busy), 16'h0000);
      clear_tflg();
    end
  endtask

  // ==========================================================
  // clock, watchdog, main sequence
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      results();
    end
  end

  initial
  begin
    reset_n = 1'b0;
    src_req = '0;
    req_clr = '0;
    src_enable = '1;
    src_level = {NS{4'h1}};
    cpu_level = 4'h0;
    trap_return = 1'b0;
    hw_trap = 9'h000;
    tflg_clr = 16'h0000;
    stall = 1'b0;
    lag = 4'h0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    chk("rst_valid", 16'(vec_valid), 16'h0000);
    chk("rst_tflg", tflg, 16'h0000);
    map_all();
    prio_check();
    trap_check();
    results();
  end
endmodule
